// ==== tb/external_bus_port_interface_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) chk(n, 16'(e), 16'(g))
module external_bus_port_interface_test
   import xbp_pkg::*;
;
   logic clk = 0, sys_rst = 1, rstPin = 0, reqValid = 0, xs = 0, xc = 0;
   logic pu = 0, we = 0, txd = 1, devRst, reqReady, doneValid, xe, ale;
   logic fs_n, wn, ea = 1, ic;
   logic [7:0] p0p, p2p, p3p;
   xbp_req_s req = '0;
   logic [3:0] mc = 4'h2, p4o, p4oe, dir = 4'hF, p4p;
   logic [7:0] waitClk = 8'h00, p3Ext = 8'hFF, rdata, p0PullupOn, p0In, nw;
   logic [4:0] alt;
   xbp_pin_s p0, p2, p3;
   int n_mismatch = 0, n_checks = 0, lat, l2;
   always #2.5 clk = ~clk;
   xbp_bus_port dut (.clk(clk), .sys_rst(sys_rst), .rstPin(rstPin),
      .devRst(devRst), .extProgramSelect(ea), .internalCode(ic),
      .reqValid(reqValid), .req(req), .reqReady(reqReady),
      .doneValid(doneValid), .rdata(rdata), .moveCycles(mc),
      .onchipXramEnableSet(xs), .onchipXramEnableClr(xc),
      .onchipXramEnable(xe), .p0PullupEnable(pu), .waitEnable(we),
      .p0Latch(8'hFF), .p2Latch(8'hFF), .p3Latch(8'hFF), .p4Latch(4'hF),
      .p4Dir(dir), .altTxd(txd), .altRxd(alt[0]), .extIrqZero(alt[1]),
      .extIrqOne(alt[2]), .counterZeroInput(alt[3]),
      .counterOneInput(alt[4]), .p0Pins(p0p), .p2Pins(p2p),
      .p3Pins(p3p), .p4Pins(p4p), .p0In(p0In), .p0(p0),
      .p0PullupOn(p0PullupOn),
      .p2In(p2.o | ~p2.oe), .p2(p2), .p3In(p3Ext & (p3.o | ~p3.oe)),
      .p3(p3), .p4In({p4o[3:1] | ~p4oe[3:1], wn}), .p4o(p4o),
      .p4oe(p4oe), .addrLatchStrobe(ale), .programFetchStrobe_n(fs_n));
   xbp_ext_mem mem (.clk(clk), .p0(p0), .p2(p2), .p3(p3),
      .p0PullupOn(p0PullupOn), .ale(ale), .fetchStrobe_n(fs_n),
      .waitClk(waitClk), .p0In(p0In), .waitPin_n(wn), .nWrites(nw));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Request held one edge with ready high, then dropped
   task automatic acc(xbp_kind_e k, logic [15:0] a, logic [7:0] d);
      int i;
      i = 0;
      @(negedge clk);
      while (reqReady !== 1'b1 && i < 200) begin
         @(negedge clk);
         i++;
      end
      req = '{k, a, d};
      reqValid = 1;
      @(negedge clk);
      reqValid = 0;
      lat = 1;
      while (doneValid !== 1'b1 && lat < 300) begin
         @(negedge clk);
         lat++;
      end
      if (i >= 200 || lat >= 300) begin
         `CHK("handshake", 0, 1);
         conclude();
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1;
      @(negedge clk) s = 0;
   endtask
   initial begin
      repeat (5) @(negedge clk);
      sys_rst = 0;
      repeat (12) @(negedge clk);
      `CHK("devRst", 0, devRst);
      `CHK("xramEn", 0, xe);
      `CHK("intCode", 1, ic);
      rstPin = 1;
      repeat (3) @(negedge clk);
      rstPin = 0;
      repeat (6) @(negedge clk);
      `CHK("shortPin", 0, devRst);
      rstPin = 1;
      repeat (14) @(negedge clk);
      `CHK("longPin", 1, devRst);
      rstPin = 0;
      repeat (14) @(negedge clk);
      $display("test reset done");
      acc(XBP_XWR, 16'h1234, 8'hA5);
      acc(XBP_XRD, 16'h1234, 8'h00);
      `CHK("extRead", 8'hA5, rdata);
      acc(XBP_FETCH, 16'h0100, 8'h00);
      `CHK("fetch", 8'h01, rdata);
      acc(XBP_TABLE, 16'hBEEF, 8'h00);
      `CHK("table", 8'h51, rdata);
      acc(XBP_XRD, 16'h4321, 8'h00);
      l2 = lat;
      mc = 4'h9;
      acc(XBP_XRD, 16'h4321, 8'h00);
      `CHK("stretch", (MOVE_MC_MAX - MOVE_MC_MIN) * CLK_PER_MC, lat - l2);
      $display("test external access done");
      mc = 4'h2;
      we = 1;
      waitClk = 8'd10;
      acc(XBP_XRD, 16'h4321, 8'h00);
      `CHK("waitRead", 8'h62, rdata);
      `CHK("waitLonger", 1, lat - l2 >= 4);
      `CHK("waitInput", 4'hE, p4oe);
      we = 0;
      waitClk = 8'h00;
      @(negedge clk);
      `CHK("waitOff", 4'hF, p4oe);
      $display("test wait done");
      pulse(xs);
      `CHK("xramOn", 1, xe);
      l2 = nw;
      acc(XBP_XWR, 16'h03FF, 8'h3C);
      acc(XBP_XRD, 16'h03FF, 8'h00);
      `CHK("xramRead", 8'h3C, rdata);
      `CHK("xramNoBus", l2, nw);
      acc(XBP_XWR, 16'h0400, 8'h77);
      `CHK("aboveWin", l2 + 1, nw);
      pulse(xc);
      `CHK("xramOff", 0, xe);
      $display("test sram window done");
      pu = 1;
      repeat (2) @(negedge clk);
      `CHK("pullOn", 8'hFF, p0PullupOn);
      `CHK("p0Pins", 8'hFF, p0p);
      pu = 0;
      p3Ext = 8'hEA;
      txd = 0;
      ea = 0;
      dir = 4'h5;
      repeat (6) @(negedge clk);
      `CHK("pullOff", 8'h00, p0PullupOn);
      `CHK("altIn", 5'h14, alt);
      `CHK("altTxd", 0, p3.o[1]);
      `CHK("p3Pins", 8'hE8, p3p);
      `CHK("p2Pins", 8'hFF, p2p);
      `CHK("p4Dir", 4'h5, p4oe);
      `CHK("p4Pins", 4'hF, p4p);
      `CHK("extCode", 0, ic);
      ea = 1;
      $display("test ports done");
      conclude();
   end
   initial begin
      repeat (100000) @(posedge clk);
      `CHK("runLimit", 0, 1);
      conclude();
   end
endmodule
`default_nettype wire

// ==== tb/xbp_bus_port_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module xbp_bus_port_sva
   import xbp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       reqReady,
   input  wire logic       onchipXramEnable,
   input  wire logic       waitEnable,
   input  wire xbp_pin_s   p0,
   input  wire xbp_pin_s   p2,
   input  wire xbp_pin_s   p3,
   input  wire logic [3:0] p4oe,
   input  wire logic       addrLatchStrobe,
   input  wire logic       programFetchStrobe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic strobeOn;
   assign strobeOn = !p3.o[6] || !p3.o[7] || !programFetchStrobe_n;
   sequence s_rd_fall; $fell(p3.o[7]); endsequence
   sequence s_wr_fall; $fell(p3.o[6]); endsequence
   a_addr_driven: assert property (
      addrLatchStrobe |-> p0.oe == 8'hFF && p2.oe == 8'hFF)
      else $error("address bus not driven");
   a_read_min_mc: assert property (
      s_rd_fall |-> !p3.o[7] [*4])
      else $error("read strobe shorter than a machine cycle");
   a_write_min_mc: assert property (
      s_wr_fall |-> !p3.o[6] [*4])
      else $error("write strobe shorter than a machine cycle");
   a_read_bus_free: assert property (
      !p3.o[7] || !programFetchStrobe_n |-> p0.oe == 8'h00)
      else $error("port 0 driven while reading");
   a_write_data: assert property (
      !p3.o[6] |-> p0.oe == 8'hFF)
      else $error("write data not driven");
   a_strobe_excl: assert property (
      $onehot0({!p3.o[6], !p3.o[7], !programFetchStrobe_n}))
      else $error("strobes overlap");
   a_ale_idle_strobe: assert property (
      strobeOn |-> !addrLatchStrobe)
      else $error("latch strobe during data phase");
   a_busy_strobe: assert property (
      strobeOn |-> !reqReady)
      else $error("ready while access active");
   a_xram_reset: assert property (
      $past(sys_rst) |-> !onchipXramEnable)
      else $error("sram enable set after reset");
   a_wait_input: assert property (
      waitEnable && $past(waitEnable) |-> !p4oe[0])
      else $error("wait pin driven");
endmodule
bind xbp_bus_port xbp_bus_port_sva chk (.clk(clk), .sys_rst(sys_rst),
   .reqReady(reqReady), .onchipXramEnable(onchipXramEnable),
   .waitEnable(waitEnable), .p0(p0), .p2(p2), .p3(p3), .p4oe(p4oe),
   .addrLatchStrobe(addrLatchStrobe),
   .programFetchStrobe_n(programFetchStrobe_n));
`default_nettype wire

// ==== tb/xbp_ext_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module xbp_ext_mem
   import xbp_pkg::*;
(
   input  wire logic       clk,
   input  wire xbp_pin_s   p0,
   input  wire xbp_pin_s   p2,
   input  wire xbp_pin_s   p3,
   input  wire logic [7:0] p0PullupOn,
   input  wire logic       ale,
   input  wire logic       fetchStrobe_n,
   input  wire logic [7:0] waitClk,
   output logic [7:0]      p0In,
   output logic            waitPin_n,
   output logic [7:0]      nWrites
);
   logic [7:0]  mem [logic [15:0]];
   logic [15:0] addr = 16'h0000;
   logic [7:0]  last = 8'h00;
   logic [7:0]  rd = 8'h00;
   logic [7:0]  waitCnt = 8'h00;
   logic        prev = 1'b1;
   initial nWrites = 8'h00;
   // Read data fixed at address latch; earlier writes are already stored
   always @(negedge ale) begin
      addr = {p2.o, p0.o};
      rd   = mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[15:8];
   end
   always @(posedge p3.o[6]) begin
      if (p0.oe === 8'hFF) begin
         mem[addr] = p0.o;
         nWrites++;
      end
   end
   // Released bus without pull-ups toggles so a stale value never looks valid
   always @* begin
      if (p0.oe === 8'hFF) p0In = p0.o;
      else if (!p3.o[7] || !fetchStrobe_n) p0In = rd;
      else if (p0PullupOn === 8'hFF) p0In = 8'hFF;
      else p0In = ~last;
   end
   always @(posedge clk) begin
      last <= p0In;
      prev <= p3.o[6] & p3.o[7];
      if (prev && !(p3.o[6] & p3.o[7])) waitCnt <= waitClk;
      else if (waitCnt != 8'h00) waitCnt <= waitCnt - 8'h01;
   end
   assign waitPin_n = (waitCnt == 8'h00);
endmodule
`default_nettype wire

// ==== verilog/xbp_bus_port.sv ====
// Notes on behaviour
// - A machine cycle is four clocks; read and write strobes step on it.
// - Reset pin held high two machine cycles resets the block.
// - Program fetch strobe asserted for external fetches and table reads.
// - Address latch strobe lets a latch catch port 0 low address.
// - Port 0 carries low address first, then data.
// - Port 0 driven high and low as bus, else open drain.
// - Port 0 pull-ups on only when software enables them.
// - Port 2 drives high address actively during external accesses.
// - Port 3 bit 6 is write strobe, bit 7 read strobe.
// - Software sets data move length from two to nine machine cycles.
// - With on-chip SRAM on, 0000H-03FFH moves go internal.
// - Wait enabled makes port 4 bit 0 input only.
// - Port 3 routes serial, interrupt and counter alternate functions.
// - Port 4 is four-bit bidirectional, bit 0 optionally wait.
// - Port 0 is the bus for external code and moves.
// - Reset clears the on-chip SRAM enable.
// - Moves above 03FFH always go to the external bus.
`timescale 1ns/100ps
`default_nettype none
module xbp_bus_port
   import xbp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        rstPin,
   output logic             devRst,
   input  wire logic        extProgramSelect,
   output logic             internalCode,
   input  wire logic        reqValid,
   input  wire xbp_req_s    req,
   output logic             reqReady,
   output logic             doneValid,
   output logic [7:0]       rdata,
   input  wire logic [3:0]  moveCycles,
   input  wire logic        onchipXramEnableSet,
   input  wire logic        onchipXramEnableClr,
   output logic             onchipXramEnable,
   input  wire logic        p0PullupEnable,
   input  wire logic        waitEnable,
   input  wire logic [7:0]  p0Latch,
   input  wire logic [7:0]  p2Latch,
   input  wire logic [7:0]  p3Latch,
   input  wire logic [3:0]  p4Latch,
   input  wire logic [3:0]  p4Dir,
   input  wire logic        altTxd,
   output logic             altRxd,
   output logic             extIrqZero,
   output logic             extIrqOne,
   output logic             counterZeroInput,
   output logic             counterOneInput,
   output logic [7:0]       p0Pins,
   output logic [7:0]       p2Pins,
   output logic [7:0]       p3Pins,
   output logic [3:0]       p4Pins,
   input  wire logic [7:0]  p0In,
   output xbp_pin_s         p0,
   output logic [7:0]       p0PullupOn,
   input  wire logic [7:0]  p2In,
   output xbp_pin_s         p2,
   input  wire logic [7:0]  p3In,
   output xbp_pin_s         p3,
   input  wire logic [3:0]  p4In,
   output logic [3:0]       p4o,
   output logic [3:0]       p4oe,
   output logic             addrLatchStrobe,
   output logic             programFetchStrobe_n
);

   // Pin synchronisers: first stage read only by the second
   logic [7:0] p0S1, p0S2, p2S1, p2S2, p3S1, p3S2;
   logic [3:0] p4S1, p4S2;
   logic       rstS1, rstS2, eaS1, eaS2;
   always_ff @(posedge clk) begin
      p0S1  <= p0In;
      p0S2  <= p0S1;
      p2S1  <= p2In;
      p2S2  <= p2S1;
      p3S1  <= p3In;
      p3S2  <= p3S1;
      p4S1  <= p4In;
      p4S2  <= p4S1;
      rstS1 <= rstPin;
      rstS2 <= rstS1;
      eaS1  <= extProgramSelect;
      eaS2  <= eaS1;
   end
   assign p0Pins = p0S2;
   assign p2Pins = p2S2;
   assign p3Pins = p3S2;
   assign p4Pins = p4S2;
   assign internalCode = eaS2;

   // Machine cycle divider
   logic [1:0] phase, next_phase;
   logic       mcTick;
   always_comb begin
      next_phase = phase + 2'h1;
      mcTick     = (phase == 2'(CLK_PER_MC - 1));
   end

   // Reset pin qualifier: must stay high a full two machine cycles
   logic [3:0] rstCnt, next_rstCnt;
   logic       rstHit;
   always_comb begin
      rstHit      = 1'b0;
      next_rstCnt = 4'h0;
      if (rstS2) begin
         if (rstCnt == 4'(RST_HOLD_CLK - 1)) begin
            rstHit      = 1'b1;
            next_rstCnt = rstCnt;
         end else begin
            next_rstCnt = rstCnt + 4'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rstCnt <= 4'h0;
         devRst <= 1'b1;
      end else begin
         rstCnt <= next_rstCnt;
         devRst <= rstHit;
      end
   end

   logic rst;
   assign rst = sys_rst | devRst;

   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 2'h0;
      end else begin
         phase <= next_phase;
      end
   end

   // On-chip SRAM enable; set wins over clear
   logic next_xen;
   always_comb begin
      next_xen = onchipXramEnable;
      if (onchipXramEnableClr) begin
         next_xen = 1'b0;
      end
      if (onchipXramEnableSet) begin
         next_xen = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         onchipXramEnable <= 1'b0;
      end else begin
         onchipXramEnable <= next_xen;
      end
   end

   logic [7:0] xram [XRAM_DEPTH];

   // Access sequencer
   xbp_state_e  state, next_state;
   xbp_req_s    cur, next_cur;
   logic [3:0]  mcLeft, next_mcLeft;
   logic [7:0]  next_rdata;
   logic        next_done, isData, isInternal, waitReq;
   logic        xramWe;

   assign isData     = cur.kind[1];
   assign isInternal = onchipXramEnable && (req.addr <= XRAM_LAST);
   assign waitReq    = waitEnable & ~p4S2[0];
   assign reqReady   = (state == XBP_IDLE) && mcTick; // Last clock of each idle machine cycle

   always_comb begin
      next_state  = state;
      next_cur    = cur;
      next_mcLeft = mcLeft;
      next_rdata  = rdata;
      next_done   = 1'b0;
      xramWe      = 1'b0;
      case (state)
         XBP_IDLE: begin
            if (reqValid && reqReady && req.kind[1] && isInternal) begin
               next_done = 1'b1;
               if (req.kind == XBP_XWR) begin
                  xramWe = 1'b1;
               end else begin
                  next_rdata = xram[req.addr[9:0]];
               end
            end else if (reqValid && reqReady) begin
               next_cur   = req;
               next_state = XBP_ADDR;
               if (moveCycles < MOVE_MC_MIN) begin
                  next_mcLeft = MOVE_MC_MIN - 4'h1;
               end else if (moveCycles > MOVE_MC_MAX) begin
                  next_mcLeft = MOVE_MC_MAX - 4'h1;
               end else begin
                  next_mcLeft = moveCycles - 4'h1;
               end
            end
         end
         XBP_ADDR: begin
            if (mcTick) begin
               next_state = XBP_DATA;
            end
         end
         XBP_DATA: begin
            if (mcTick) begin
               if (isData && mcLeft > 4'h1) begin
                  next_mcLeft = mcLeft - 4'h1;
                  next_state  = XBP_STRUNG;
               end else if (isData && waitReq) begin
                  next_state = XBP_WAIT;
               end else begin
                  next_state = XBP_DONE;
               end
            end
         end
         XBP_STRUNG: begin
            if (mcTick) begin
               if (mcLeft > 4'h1) begin
                  next_mcLeft = mcLeft - 4'h1;
               end else if (waitReq) begin
                  next_state = XBP_WAIT;
               end else begin
                  next_state = XBP_DONE;
               end
            end
         end
         XBP_WAIT: begin
            if (mcTick && !waitReq) begin
               next_state = XBP_DONE;
            end
         end
         XBP_DONE: begin
            next_done  = 1'b1;
            next_state = XBP_IDLE;
            if (cur.kind != XBP_XWR) begin
               next_rdata = p0S2;
            end
         end
         default: begin
            next_state = XBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= XBP_IDLE;
         cur       <= '0;
         mcLeft    <= 4'h0;
         rdata     <= 8'h00;
         doneValid <= 1'b0;
      end else begin
         state     <= next_state;
         cur       <= next_cur;
         mcLeft    <= next_mcLeft;
         rdata     <= next_rdata;
         doneValid <= next_done;
      end
   end

   // SRAM storage, no reset needed
   always_ff @(posedge clk) begin
      if (xramWe) begin
         xram[req.addr[9:0]] <= req.wdata;
      end
   end

   // Pin drive
   logic busy, strobe;
   assign busy   = (state != XBP_IDLE);
   assign strobe = (state == XBP_DATA) || (state == XBP_STRUNG) ||
                   (state == XBP_WAIT);

   always_ff @(posedge clk) begin
      if (rst) begin
         addrLatchStrobe      <= 1'b0;
         programFetchStrobe_n <= 1'b1;
         p0                   <= '{o: 8'h00, oe: 8'h00};
         p2                   <= '{o: PORT_RST, oe: 8'h00};
         p3                   <= '{o: PORT_RST, oe: 8'h00};
         p4o                  <= P4_RST;
         p4oe                 <= 4'h0;
      end else begin
         addrLatchStrobe      <= (next_state == XBP_ADDR) && (phase < 2'h2);
         programFetchStrobe_n <= !(next_state inside {XBP_DATA, XBP_DONE} &&
                                   !next_cur.kind[1]);
         if (next_state == XBP_ADDR) begin
            p0.o  <= next_cur.addr[7:0];
            p0.oe <= 8'hFF;
         end else if (next_state != XBP_IDLE && next_cur.kind == XBP_XWR) begin
            p0.o  <= next_cur.wdata;
            p0.oe <= 8'hFF;
         end else if (next_state != XBP_IDLE) begin
            p0.o  <= 8'h00;
            p0.oe <= 8'h00;
         end else begin
            p0.o  <= 8'h00;
            p0.oe <= ~p0Latch;
         end
         if (next_state != XBP_IDLE) begin
            p2.o  <= next_cur.addr[15:8];
            p2.oe <= 8'hFF;
         end else begin
            p2.o  <= p2Latch;
            p2.oe <= ~p2Latch;
         end
         p3.o  <= p3Latch;
         p3.oe <= ~p3Latch;
         p3.o[P3_TXD]  <= altTxd;
         p3.oe[P3_TXD] <= ~altTxd;
         if (busy || strobe) begin
            p3.o[P3_WR]  <= !((next_state inside {XBP_DATA, XBP_STRUNG,
                              XBP_WAIT}) && next_cur.kind == XBP_XWR);
            p3.oe[P3_WR] <= 1'b1;
            p3.o[P3_RD]  <= !((next_state inside {XBP_DATA, XBP_STRUNG,
                              XBP_WAIT}) && next_cur.kind == XBP_XRD);
            p3.oe[P3_RD] <= 1'b1;
         end
         p4o  <= p4Latch;
         p4oe <= p4Dir;
         if (waitEnable) begin
            p4oe[0] <= 1'b0;
         end
      end
   end

   assign p0PullupOn       = p0PullupEnable ? 8'hFF : 8'h00;
   assign altRxd           = p3S2[P3_RXD];
   assign extIrqZero       = p3S2[P3_IRQ0];
   assign extIrqOne        = p3S2[P3_IRQ1];
   assign counterZeroInput = p3S2[P3_CNT0];
   assign counterOneInput  = p3S2[P3_CNT1];

endmodule
`default_nettype wire

// ==== verilog/xbp_pkg.sv ====
package xbp_pkg;

   // Machine cycle and reset timing
   localparam int CLK_PER_MC      = 4;
   localparam int RST_HOLD_MC     = 2;
   localparam int RST_HOLD_CLK    = RST_HOLD_MC * CLK_PER_MC;

   // External data move stretch limits, in machine cycles
   localparam logic [3:0] MOVE_MC_MIN = 4'h2;
   localparam logic [3:0] MOVE_MC_MAX = 4'h9;

   // On-chip data SRAM window
   localparam logic [15:0] XRAM_LAST  = 16'h03FF;
   localparam int          XRAM_DEPTH = 1024;

   // Reset values
   localparam logic [7:0] PORT_RST = 8'hFF;
   localparam logic [3:0] P4_RST   = 4'hF;

   // Bit positions of port 3 alternate functions
   localparam int P3_RXD  = 0;
   localparam int P3_TXD  = 1;
   localparam int P3_IRQ0 = 2;
   localparam int P3_IRQ1 = 3;
   localparam int P3_CNT0 = 4;
   localparam int P3_CNT1 = 5;
   localparam int P3_WR   = 6;
   localparam int P3_RD   = 7;

   typedef enum logic [2:0] {
      XBP_IDLE   = 3'b000,
      XBP_ADDR   = 3'b001,
      XBP_DATA   = 3'b010,
      XBP_STRUNG = 3'b011,
      XBP_WAIT   = 3'b100,
      XBP_DONE   = 3'b101
   } xbp_state_e;

   typedef enum logic [1:0] {
      XBP_FETCH = 2'b00,
      XBP_TABLE = 2'b01,
      XBP_XRD   = 2'b10,
      XBP_XWR   = 2'b11
   } xbp_kind_e;

   // Core-side access request
   typedef struct packed {
      xbp_kind_e   kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } xbp_req_s;

   // Pin group: output and output enable
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } xbp_pin_s;

endpackage
